// ### core/scs_sequencer.sv
/*
 * Digital sequencer of a 10-bit SAR converter working as ADC or DAC,
 * with an APB register slave. Assumes the analog front end, comparator
 * and timers run on sys_clk; the converter clock is an enable pulse.
 */
`default_nettype none
module scs_sequencer #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// APB slave.
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output var  logic              pready,
	output var  logic [31:0]       prdata,
	output var  logic              pslverr,
	// Events and comparator.
	input  wire logic [2:0]        timer_ovf,
	input  wire logic              isr_ack,
	input  wire logic              cmp_high,
	// Analog front end controls.
	output var  logic [2:0]        ch_sel,
	output var  logic              pair_mode,
	output var  logic              int_src,
	output var  logic              input_connected,
	output var  logic              sample_hold,
	output var  logic [9:0]        sar_trial,
	output var  logic [9:0]        dac_out,
	output var  logic              dac_pins_input_only,
	output var  logic              conv_power_on,
	output var  logic              osc_keep_on,
	output var  logic              done_flag
);
	// Register fields.
	logic [2:0]  clk_sel;
	logic        left_justify;
	logic        conv_en;
	logic        dac_mode;
	logic        busy;
	logic        connect;
	logic [1:0]  trig_sel;
	logic        isrc;
	logic        pair;
	logic [2:0]  chan;
	logic [7:0]  dac_hi;
	logic [7:0]  dac_lo;
	logic [9:0]  result;
	logic [9:0]  dac_buf;
	// Sequencer state.
	scs_pkg::scs_state_t state;
	logic [3:0]  cyc;
	logic        sync_tick_seen;
	logic [1:0]  sync_cnt;
	logic        finish;
	// Clock generation.
	logic [6:0]  pre_cnt;
	logic [3:0]  int_cnt;
	logic        int_tick;
	logic        conv_tick;
	// Bus decode.
	logic        wr_en;
	logic        sw_start;
	logic        hw_start;
	logic        start;
	logic [3:0]  n;
	logic [3:0]  bit_idx;
	logic [9:0]  next_trial;
	logic [15:0] res_word;
	logic [6:0]  pre_mask;
	logic [31:0] next_rdata;
	logic        next_err;

	// A write lands only on the edge where the master sees pready.
	assign wr_en = psel & penable & pready & pwrite;
	assign sw_start = wr_en && paddr[7:0] == scs_pkg::CTRL_OFF
		&& pwdata[scs_pkg::CTRL_BUSY] && conv_en;
	assign hw_start = trig_sel != 2'h0_000 && conv_en
		&& timer_ovf[trig_sel - 2'h0_001];
	assign start = (sw_start | hw_start) && state == scs_pkg::ST_IDLE;
	// Cycle number the current tick begins.
	assign n = cyc + 4'h0_001;
	assign bit_idx = scs_pkg::ADC_CYCLES - n;

	// Trial word: keep the bit under test if the comparator agrees,
	// then try the next lower bit.
	always_comb begin
		next_trial = sar_trial;
		if (!cmp_high) begin
			next_trial[bit_idx] = 1'b0;
		end
		if (bit_idx != 4'h0_000) begin
			next_trial[bit_idx - 4'h0_001] = 1'b1;
		end
	end

	// Sign-extend right-justified, zero-fill left-justified.
	assign res_word = left_justify ? {result, 6'h0_00}
		: {{6{result[9]}}, result};

	// Seven-bit prescaler and internal-oscillator divider run freely.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_cnt <= 7'h0_000;
			int_cnt <= 4'h0_000;
			int_tick <= 1'b0;
		end else begin
			pre_cnt <= pre_cnt + 7'h0_001;
			int_tick <= int_cnt == 4'(scs_pkg::INT_DIV - 1);
			if (int_cnt == 4'(scs_pkg::INT_DIV - 1)) begin
				int_cnt <= 4'h0_000;
			end else begin
				int_cnt <= int_cnt + 4'h0_001;
			end
		end
	end

	// Divide by two to the clk_sel from the prescaler, else internal.
	assign pre_mask = 7'((8'h0_001 << clk_sel) - 8'h0_001);
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_tick <= 1'b0;
		end else if (clk_sel == 3'h0_000) begin
			conv_tick <= int_tick;
		end else begin
			conv_tick <= (pre_cnt | ~pre_mask) == 7'h0_07f;
		end
	end

	// Conversion sequencer; dropping enable aborts at once.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= scs_pkg::ST_IDLE;
			cyc <= 4'h0_000;
			busy <= 1'b0;
			sync_tick_seen <= 1'b0;
			sync_cnt <= 2'h0_000;
			finish <= 1'b0;
		end else begin
			finish <= 1'b0;
			case (state)
			scs_pkg::ST_IDLE: begin
				if (start) begin
					state <= scs_pkg::ST_CONV;
					cyc <= 4'h0_000;
					busy <= 1'b1;
				end
			end
			scs_pkg::ST_CONV: begin
				if (!conv_en) begin
					state <= scs_pkg::ST_IDLE;
					busy <= 1'b0;
				end else if (conv_tick) begin
					cyc <= n;
					if (n == (dac_mode ? scs_pkg::DAC_CYCLES
						: scs_pkg::ADC_CYCLES)) begin
						state <= scs_pkg::ST_SYNC;
						sync_tick_seen <= 1'b0;
						sync_cnt <= 2'h0_000;
					end
				end
			end
			scs_pkg::ST_SYNC: begin
				// One more converter clock, then two system clocks.
				if (!conv_en) begin
					state <= scs_pkg::ST_IDLE;
					busy <= 1'b0;
				end else if (!sync_tick_seen) begin
					sync_tick_seen <= conv_tick;
				end else if (sync_cnt == scs_pkg::SYNC_SYS - 2'h0_001) begin
					state <= scs_pkg::ST_IDLE;
					busy <= 1'b0;
					finish <= 1'b1;
				end else begin
					sync_cnt <= sync_cnt + 2'h0_001;
				end
			end
			default: begin
				state <= scs_pkg::ST_IDLE;
				busy <= 1'b0;
			end
			endcase
		end
	end

	// Datapath: sample, approximate, store or output.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sample_hold <= 1'b0;
			sar_trial <= 10'h0_000;
			result <= 10'h0_000;
			dac_buf <= 10'h0_000;
			dac_out <= 10'h0_000;
		end else if (state == scs_pkg::ST_IDLE) begin
			sample_hold <= 1'b0;
			if (start && dac_mode) begin
				// One system clock copies the data into the buffer.
				dac_buf <= left_justify ? {dac_hi, dac_lo[7:6]}
					: {dac_hi[1:0], dac_lo};
			end
		end else if (state == scs_pkg::ST_CONV && conv_tick) begin
			if (dac_mode) begin
				if (n == scs_pkg::DAC_BUILD) begin
					sar_trial <= dac_buf;
				end
				if (n == scs_pkg::DAC_OUT_CYCLE) begin
					dac_out <= dac_buf;
				end
			end else if (n == scs_pkg::ADC_SAMPLE) begin
				sample_hold <= 1'b1;
				sar_trial <= scs_pkg::TRIAL_MSB;
			end else if (n > scs_pkg::ADC_SAMPLE) begin
				sar_trial <= next_trial;
				if (n == scs_pkg::ADC_CYCLES) begin
					// Offset code to two's complement.
					result <= next_trial ^ scs_pkg::SIGN_FLIP;
				end
			end
		end
	end

	// Done flag: completion wins over a service-entry clear.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_flag <= 1'b0;
		end else if (finish) begin
			done_flag <= 1'b1;
		end else if (isr_ack) begin
			done_flag <= 1'b0;
		end
	end

	// Software-writable fields.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{conv_en, dac_mode, left_justify, clk_sel} <= 6'h0_000;
			{connect, trig_sel, isrc, pair, chan} <= scs_pkg::REG_RESET;
			dac_hi <= scs_pkg::REG_RESET;
			dac_lo <= scs_pkg::REG_RESET;
		end else if (wr_en) begin
			case (paddr[7:0])
			scs_pkg::CTRL_OFF: begin
				conv_en <= pwdata[scs_pkg::CTRL_EN];
				dac_mode <= pwdata[scs_pkg::CTRL_DAC];
				left_justify <= pwdata[scs_pkg::CTRL_LJ];
				clk_sel <= pwdata[scs_pkg::CTRL_CKS_L +: 3];
			end
			scs_pkg::INPUT_OFF: begin
				connect <= pwdata[scs_pkg::IN_CONN];
				trig_sel <= pwdata[scs_pkg::IN_TRG_L +: 2];
				isrc <= pwdata[scs_pkg::IN_ISRC];
				pair <= pwdata[scs_pkg::IN_PAIR];
				chan <= pwdata[scs_pkg::IN_CH_L +: 3];
			end
			scs_pkg::RES_H_OFF: begin
				if (dac_mode) begin
					dac_hi <= pwdata[7:0];
				end
			end
			scs_pkg::RES_L_OFF: begin
				if (dac_mode) begin
					dac_lo <= pwdata[7:0];
				end
			end
			default: begin
			end
			endcase
		end
	end

	// Read mux; result reads zero in DAC mode, where it is write-only.
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		case (paddr[7:0])
		scs_pkg::CTRL_OFF: begin
			next_rdata[7:0] = {done_flag, busy, dac_mode, conv_en,
				left_justify, clk_sel};
		end
		scs_pkg::INPUT_OFF: begin
			next_rdata[7:0] = {connect, trig_sel, isrc, pair, chan};
		end
		scs_pkg::RES_H_OFF: begin
			next_rdata[7:0] = dac_mode ? 8'h0_000 : res_word[15:8];
		end
		scs_pkg::RES_L_OFF: begin
			next_rdata[7:0] = dac_mode ? 8'h0_000 : res_word[7:0];
		end
		default: begin
			next_err = 1'b1;
		end
		endcase
	end

	// APB answer one cycle into the access phase; wait state by design.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & next_err;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// Pin controls; DAC mode drops the pair and connect selections.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ch_sel <= 3'h0_000;
			pair_mode <= 1'b0;
			int_src <= 1'b0;
			input_connected <= 1'b0;
			dac_pins_input_only <= 1'b0;
			conv_power_on <= 1'b0;
			osc_keep_on <= 1'b0;
		end else begin
			ch_sel <= chan;
			pair_mode <= pair & ~dac_mode;
			// Internal source only means something on channel six.
			int_src <= isrc && chan == scs_pkg::CH_INTERNAL;
			input_connected <= connect & conv_en & ~dac_mode;
			dac_pins_input_only <= conv_en & dac_mode;
			conv_power_on <= conv_en;
			osc_keep_on <= conv_en && clk_sel == 3'h0_000;
		end
	end
endmodule : scs_sequencer
`default_nettype wire

// ### core/scs_pkg.sv
/*
 * Constants, register map and state type for the converter sequencer.
 * Assumes a 20 MHz system clock and an APB master with 32-bit data.
 */
`default_nettype none
package scs_pkg;
	// Clock rates, and the internal 2 MHz converter clock as a divide count.
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int INT_CLK_HZ = 2_000_000;
	localparam int INT_DIV    = SYS_CLK_HZ / INT_CLK_HZ;
	// Conversion lengths and key cycles in converter clocks; SYNC_SYS in system clocks.
	localparam logic [3:0] ADC_CYCLES    = 4'h0_00d;
	localparam logic [3:0] ADC_SAMPLE    = 4'h0_003;
	localparam logic [3:0] DAC_CYCLES    = 4'h0_00b;
	localparam logic [3:0] DAC_BUILD     = 4'h0_002;
	localparam logic [3:0] DAC_OUT_CYCLE = 4'h0_007;
	localparam logic [1:0] SYNC_SYS      = 2'h0_002;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFF  = 8'h0_000;
	localparam logic [7:0] INPUT_OFF = 8'h0_004;
	localparam logic [7:0] RES_H_OFF = 8'h0_008;
	localparam logic [7:0] RES_L_OFF = 8'h0_00c;
	// Control register fields.
	localparam int CTRL_DONE  = 7;
	localparam int CTRL_BUSY  = 6;
	localparam int CTRL_DAC   = 5;
	localparam int CTRL_EN    = 4;
	localparam int CTRL_LJ    = 3;
	localparam int CTRL_CKS_L = 0;
	// Input register fields.
	localparam int IN_CONN   = 7;
	localparam int IN_TRG_L  = 5;
	localparam int IN_ISRC   = 4;
	localparam int IN_PAIR   = 3;
	localparam int IN_CH_L   = 0;
	// Channel that reaches the internal sources, and the signed flip.
	localparam logic [2:0] CH_INTERNAL = 3'h0_006;
	localparam logic [9:0] SIGN_FLIP   = 10'h0_200;
	localparam logic [9:0] TRIAL_MSB   = 10'h0_200;
	localparam logic [7:0] REG_RESET   = 8'h0_000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_SYNC = 3'b100
	} scs_state_t;
endpackage : scs_pkg
`default_nettype wire

// ### bench/scs_sequencer_asserts.sv
/* Port checker for the converter sequencer.
   Assumes it is bound to every sequencer instance by the bind below. */
`default_nettype none
module scs_sequencer_asserts (
	// Clock and reset.
	input wire logic       sys_clk,
	input wire logic       arst_n,
	// Bus and events.
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       isr_ack,
	// Front end controls.
	input wire logic [2:0] ch_sel,
	input wire logic       pair_mode,
	input wire logic       int_src,
	input wire logic       input_connected,
	input wire logic       sample_hold,
	input wire logic [9:0] sar_trial,
	input wire logic [9:0] dac_out,
	input wire logic       dac_pins_input_only,
	input wire logic       conv_power_on,
	input wire logic       done_flag
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Ready answers only an access phase and lasts one cycle.
	property p_ready;
		pready |-> psel && penable ##1 !pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready outside access or too long");
	// Pins reach the sampler only in an enabled ADC.
	property p_conn;
		input_connected |-> conv_power_on && !dac_pins_input_only;
	endproperty
	a_conn: assert property (p_conn)
		else $error("input connected while off or in DAC mode");
	// An enabled DAC ignores the pair bit.
	property p_dac_pins;
		dac_pins_input_only |-> conv_power_on && !pair_mode;
	endproperty
	a_dac_pins: assert property (p_dac_pins)
		else $error("DAC pins forced without enable or pair kept");
	// The internal source bit matters only on the internal channel.
	property p_int_src;
		int_src |-> ch_sel == scs_pkg::CH_INTERNAL;
	endproperty
	a_int_src: assert property (p_int_src)
		else $error("internal source on a pin channel");
	// A disabled converter stops sampling within one cycle.
	property p_power;
		!conv_power_on |=> !sample_hold;
	endproperty
	a_power: assert property (p_power)
		else $error("sampling while disabled");
	// Sampling starts with the midscale trial code.
	property p_sample;
		$rose(sample_hold) |-> sar_trial == scs_pkg::TRIAL_MSB;
	endproperty
	a_sample: assert property (p_sample)
		else $error("trial not midscale at sample");
	// Only interrupt entry takes the done flag down.
	property p_done_clr;
		$fell(done_flag) |-> $past(isr_ack);
	endproperty
	a_done_clr: assert property (p_done_clr)
		else $error("done flag cleared without service entry");
	// The analog output moves only in DAC mode.
	property p_dac_hold;
		$changed(dac_out) |-> dac_pins_input_only;
	endproperty
	a_dac_hold: assert property (p_dac_hold)
		else $error("DAC output changed outside DAC mode");
endmodule : scs_sequencer_asserts

bind scs_sequencer scs_sequencer_asserts i_scs_sequencer_asserts (
	.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pready(pready), .isr_ack(isr_ack), .ch_sel(ch_sel),
	.pair_mode(pair_mode), .int_src(int_src),
	.input_connected(input_connected), .sample_hold(sample_hold),
	.sar_trial(sar_trial), .dac_out(dac_out),
	.dac_pins_input_only(dac_pins_input_only),
	.conv_power_on(conv_power_on), .done_flag(done_flag));
`default_nettype wire

// ### bench/scs_far_model.sv
/* Far side model: analog input behind the sample stage, and timers.
   Assumes the bench sets the input code and asks for overflows. */
`default_nettype none
module scs_far_model (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Bench requests.
	input  wire logic [9:0] vin,
	input  wire logic [2:0] ovf_req,
	// Sequencer side.
	input  wire logic       sample_hold,
	input  wire logic [9:0] sar_trial,
	output var  logic       cmp_high,
	output var  logic [2:0] timer_ovf
);
	// The analog pins are modelled as inputs only, never driven.
	logic [9:0] held;

	// The input tracks until sampled, so later changes cannot leak in.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			held <= 10'h000;
		end else if (!sample_hold) begin
			held <= vin;
		end
	end
	// The comparator answers at once on the offset code.
	assign cmp_high = held >= sar_trial;
	// Overflows are single pulses, spaced beyond a conversion.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_ovf <= 3'h0;
		end else begin
			timer_ovf <= ovf_req;
		end
	end
endmodule : scs_far_model
`default_nettype wire

// ### bench/scs_sequencer_tb.sv
/* Self-checking bench of the sequencer with an APB master.
   Assumes the checker binds itself and the far model stands beside. */
`default_nettype none
module scs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, arst_n, psel, penable, pwrite, isr_ack;
	logic        pready, pslverr, cmp_high, done_flag, dac_pio, sh, conn;
	logic [7:0]  paddr, lb;
	logic [31:0] pwdata, prdata;
	logic [2:0]  timer_ovf, ovf_req;
	logic [9:0]  trial, vin, dac_v;
	logic [32:0] exp_q[$];
	int          n_mismatch, num_checks;

	// Device under test; outputs not used here, other than osc_keep_on, go to the checker.
	scs_sequencer i_scs_sequencer (.sys_clk(sys_clk), .arst_n(arst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .timer_ovf(timer_ovf), .isr_ack(isr_ack),
		.cmp_high(cmp_high), .ch_sel(), .pair_mode(), .int_src(),
		.input_connected(conn), .sample_hold(sh), .sar_trial(trial),
		.dac_out(dac_v), .dac_pins_input_only(dac_pio), .conv_power_on(),
		.osc_keep_on(), .done_flag(done_flag));
	// Far side: held analog input and timers.
	scs_far_model i_scs_far_model (.sys_clk(sys_clk), .arst_n(arst_n),
		.vin(vin), .ovf_req(ovf_req), .sample_hold(sh),
		.sar_trial(trial), .cmp_high(cmp_high), .timer_ovf(timer_ovf));

	// Verdict and end of run.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// Compares one value and reports a difference.
	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		num_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk

	// One APB transfer; a read notes its expected error bit and data.
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d, input logic [32:0] e);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) exp_q.push_back(e);
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_mismatch++;
			end_sim();
		end
		@(posedge sys_clk);
	endtask : apb

	// Waits a bounded time for the done flag.
	task automatic wait_done();
		int k;
		k = 0;
		while (done_flag !== 1'b1 && k < 400) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 400) begin
			n_mismatch++;
			end_sim();
		end
	endtask : wait_done

	// Reads both result bytes against the signed code of the input.
	task automatic rd_result(input logic lj);
		logic [15:0] s;
		s = lj ? {vin ^ 10'h200, 6'h00} : {{6{~vin[9]}}, vin ^ 10'h200};
		apb(1'b0, 8'h08, 32'h0, {25'h0, s[15:8]});
		apb(1'b0, 8'h0c, 32'h0, {25'h0, s[7:0]});
	endtask : rd_result

	// Interrupt entry clears the done flag.
	task automatic ack();
		isr_ack <= 1'b1;
		@(posedge sys_clk);
		isr_ack <= 1'b0;
		@(posedge sys_clk);
		chk({32'h0, done_flag}, 33'h0);
	endtask : ack

	// Each read answer is matched with the oldest note.
	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			chk({pslverr, prdata}, exp_q.pop_front());
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// The converter clock runs at sys/2 to keep conversions short.
	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		isr_ack = 1'b0;
		ovf_req = 3'h0;
		vin = 10'h000;
		n_mismatch = 0;
		num_checks = 0;
		void'($urandom(32'h3369));
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, 8'h00, 32'h0, 33'h0);
		apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
		// Channel is written with connect low, then connect is set.
		apb(1'b1, 8'h04, 32'h02, 33'h0);
		apb(1'b1, 8'h04, 32'h82, 33'h0);
		for (int lj = 0; lj < 2; lj++) begin
			lb = lj ? 8'h08 : 8'h00;
			vin <= 10'($urandom());
			apb(1'b1, 8'h00, {24'h0, 8'h11 | lb}, 33'h0);
			// The pin controls are registered one cycle after the write.
			@(posedge sys_clk);
			chk({32'h0, conn}, 33'h1);
			apb(1'b1, 8'h00, {24'h0, 8'h51 | lb}, 33'h0);
			apb(1'b0, 8'h00, 32'h0, {25'h0, 8'h51 | lb});
			wait_done();
			apb(1'b0, 8'h00, 32'h0, {25'h0, 8'h91 | lb});
			rd_result(lb[3]);
			ack();
		end
		// Timer 0 overflow starts a conversion by itself.
		apb(1'b1, 8'h04, 32'ha2, 33'h0);
		vin <= 10'($urandom());
		ovf_req <= 3'h1;
		@(posedge sys_clk);
		ovf_req <= 3'h0;
		apb(1'b0, 8'h00, 32'h0, {25'h0, 8'h59});
		wait_done();
		rd_result(1'b1);
		ack();
		// DAC: pins forced input-only, inputs dropped, data write-only.
		// Converter clock stays at sys/2, below the system clock.
		apb(1'b1, 8'h00, 32'h31, 33'h0);
		@(posedge sys_clk);
		chk({32'h0, dac_pio}, 33'h1);
		chk({32'h0, conn}, 33'h0);
		apb(1'b1, 8'h08, 32'h01, 33'h0);
		apb(1'b1, 8'h0c, 32'h23, 33'h0);
		apb(1'b1, 8'h00, 32'h71, 33'h0);
		wait_done();
		chk({23'h0, dac_v}, 33'h123);
		apb(1'b0, 8'h08, 32'h0, 33'h0);
		ack();
		end_sim();
	end
endmodule : scs_sequencer_tb
`default_nettype wire
